// ===== adcr_regs.svh
/*
 * Register map, field positions and reset values of the conversion
 * result bank. Assumes the includer maps byte offsets onto a 32-bit bus.
 */
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH


// ============================================================
// result registers, byte offsets
`define ADCR_CURRENT_RESULT_OFS 8'h40
`define ADCR_INTERNAL_TEMP_RESULT_OFS 8'h44
`define ADCR_EXTERNAL_TEMP_RESULT_OFS 8'h48
`define ADCR_PACK_VOLTAGE_RESULT_OFS 8'h4C
`define ADCR_CELL_ONE_VOLTAGE_RESULT_OFS 8'h50
`define ADCR_CELL_TWO_VOLTAGE_RESULT_OFS 8'h54
`define ADCR_OFFSET_RESULT_OFS 8'h58
`define ADCR_AUXILIARY_RESULT_OFS 8'h5C

// ============================================================
// conversion control registers and status, byte offsets
`define ADCR_CTRL0_OFS 8'h20
`define ADCR_CTRL1_OFS 8'h24
`define ADCR_CTRL2_OFS 8'h28
`define ADCR_CTRL3_OFS 8'h2C
`define ADCR_CTRL4_OFS 8'h30
`define ADCR_CTRL5_OFS 8'h34
`define ADCR_CTRL6_OFS 8'h38
`define ADCR_CTRL7_OFS 8'h3C
`define ADCR_STATUS_OFS 8'h60

// ============================================================
// field positions
`define ADCR_SIGN_BIT 15
`define ADCR_MAG_MSB 14
`define ADCR_RES_MSB 6
`define ADCR_RES_LSB 4
`define ADCR_REF_BIT 3
`define ADCR_SEL_MSB 2
`define ADCR_CTRL_W 7
`define ADCR_RES_BASE_BITS 5'h08

// ============================================================
// reset values
`define ADCR_CTRL_RESET 7'h70
`define ADCR_RESULT_RESET 16'h0000

`endif

// ===== adcr_pkg.sv
/*
 * Types shared by the conversion result bank files.
 * Assumes nothing of its surroundings.
 */
package adcr_pkg;

    // ============================================================
    // bus slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } adcr_bus_state_t;

    // ============================================================
    // what an address selects
    typedef enum logic [1:0] {
        TGT_NONE = 2'h0,
        TGT_RESULT = 2'h1,
        TGT_CTRL = 2'h2,
        TGT_STATUS = 2'h3
    } adcr_target_t;

endpackage

// ===== adcr_result_mem.sv
/*
 * Result storage: one word per channel, read data out of a register.
 * Assumes writer and reader share the clock; a read in the write cycle
 * returns the old word.
 */
`timescale 1ns/1ps

`include "adcr_regs.svh"

module adcr_result_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    // read port
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [WIDTH-1:0] next_rd_data;

    // ============================================================
    // entries: whole word per write
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_comb begin
            next_mem[g] = mem[g];
            if (i_wr_en && i_wr_addr == AW'(g)) begin
                next_mem[g] = i_wr_data;
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                mem[g] <= `ADCR_RESULT_RESET;
            end else begin
                mem[g] <= next_mem[g];
            end
        end
    end

    // ============================================================
    // registered read
    always_comb begin
        next_rd_data = o_rd_data;
        if (i_rd_en) begin
            next_rd_data = mem[i_rd_addr];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rd_data <= `ADCR_RESULT_RESET;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

endmodule // adcr_result_mem

// ===== adcr_justify.sv
/*
 * Turns a right-aligned converter magnitude into a left-justified
 * sign-magnitude result word, one cycle of latency.
 * Assumes the converter supplies exactly resolution+8 magnitude bits.
 */
`timescale 1ns/1ps

`include "adcr_regs.svh"

module adcr_justify #(
    parameter int MAG_W = 15,
    parameter int RES_W = 3,
    parameter int CH_W = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // raw conversion
    input wire logic i_valid,
    input wire logic [CH_W-1:0] i_channel,
    input wire logic i_sign,
    input wire logic [MAG_W-1:0] i_magnitude,
    input wire logic [RES_W-1:0] i_resolution,
    // formatted word
    output logic o_valid,
    output logic [CH_W-1:0] o_channel,
    output logic [MAG_W:0] o_word
);

    logic [4:0] width;
    logic [4:0] shift;
    logic [MAG_W-1:0] mask;
    logic next_valid;
    logic [CH_W-1:0] next_channel;
    logic [MAG_W:0] next_word;

    // ============================================================
    // justification
    always_comb begin
        width = 5'(i_resolution) + `ADCR_RES_BASE_BITS;
        shift = 5'(MAG_W) - width;
        // for full width the shifted one falls off and the mask wraps to all ones
        mask = (MAG_W'(1) << width) - MAG_W'(1);
        next_valid = i_valid;
        next_channel = i_valid ? i_channel : o_channel;
        next_word = o_word;
        if (i_valid) begin
            next_word = {i_sign, (i_magnitude & mask) << shift};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_channel <= '0;
            o_word <= '0;
        end else begin
            o_valid <= next_valid;
            o_channel <= next_channel;
            o_word <= next_word;
        end
    end

endmodule // adcr_justify

// ===== adcr_result_bank.sv
/*
 * Conversion result bank: eight result words, eight conversion control
 * registers and a new-result status word, reached over AHB-Lite.
 * Assumes the converter logic runs on i_clk and pulses i_conv_done once
 * per finished conversion with its channel, sign and magnitude.
 */
`timescale 1ns/1ps

`include "adcr_regs.svh"

module adcr_result_bank (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // converter side
    input wire logic i_conv_done,
    input wire logic [2:0] i_conv_channel,
    input wire logic i_conv_sign,
    input wire logic [14:0] i_conv_magnitude,
    // state seen by the converter
    output logic [7:0] o_new_result,
    output logic [2:0] o_active_resolution
);

    localparam int CH_N = 8;
    localparam int CH_W = 3;
    localparam int MAG_W = `ADCR_MAG_MSB + 1;
    localparam int RES_W = `ADCR_RES_MSB - `ADCR_RES_LSB + 1;

    // ============================================================
    // declarations
    adcr_pkg::adcr_bus_state_t state;
    adcr_pkg::adcr_bus_state_t next_state;
    adcr_pkg::adcr_target_t dec_target;
    adcr_pkg::adcr_target_t tgt;
    adcr_pkg::adcr_target_t next_tgt;
    logic [CH_W-1:0] dec_index;
    logic [CH_W-1:0] idx;
    logic [CH_W-1:0] next_idx;
    logic wr;
    logic next_wr;
    logic accept;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic [`ADCR_CTRL_W-1:0] ctrl [CH_N];
    logic [`ADCR_CTRL_W-1:0] next_ctrl [CH_N];
    logic [CH_N-1:0] next_new_result;
    logic [RES_W-1:0] next_active_resolution;
    logic fmt_valid;
    logic [CH_W-1:0] fmt_channel;
    logic [MAG_W:0] fmt_word;
    logic [MAG_W:0] mem_rd_data;
    logic status_clear;

    // ============================================================
    // address decode
    always_comb begin
        dec_target = adcr_pkg::TGT_NONE;
        dec_index = '0;
        case (i_haddr[7:0])
            `ADCR_CURRENT_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h0;
            end
            `ADCR_INTERNAL_TEMP_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h1;
            end
            `ADCR_EXTERNAL_TEMP_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h2;
            end
            `ADCR_PACK_VOLTAGE_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h3;
            end
            `ADCR_CELL_ONE_VOLTAGE_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h4;
            end
            `ADCR_CELL_TWO_VOLTAGE_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h5;
            end
            `ADCR_OFFSET_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h6;
            end
            `ADCR_AUXILIARY_RESULT_OFS: begin
                dec_target = adcr_pkg::TGT_RESULT;
                dec_index = 3'h7;
            end
            `ADCR_CTRL0_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h0;
            end
            `ADCR_CTRL1_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h1;
            end
            `ADCR_CTRL2_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h2;
            end
            `ADCR_CTRL3_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h3;
            end
            `ADCR_CTRL4_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h4;
            end
            `ADCR_CTRL5_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h5;
            end
            `ADCR_CTRL6_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h6;
            end
            `ADCR_CTRL7_OFS: begin
                dec_target = adcr_pkg::TGT_CTRL;
                dec_index = 3'h7;
            end
            `ADCR_STATUS_OFS: begin
                dec_target = adcr_pkg::TGT_STATUS;
            end
            default: begin
                dec_target = adcr_pkg::TGT_NONE;
            end
        endcase
    end

    // ============================================================
    // bus state machine
    // one wait state on every access so that read data always leaves a flop
    assign accept = i_hsel && i_hready && i_htrans[1];

    always_comb begin
        next_state = state;
        next_tgt = tgt;
        next_idx = idx;
        next_wr = wr;
        case (state)
            adcr_pkg::ST_IDLE, adcr_pkg::ST_RESP: begin
                next_state = adcr_pkg::ST_IDLE;
                if (accept) begin
                    next_state = adcr_pkg::ST_WAIT;
                    next_tgt = dec_target;
                    next_idx = dec_index;
                    next_wr = i_hwrite;
                end
            end
            adcr_pkg::ST_WAIT: begin
                next_state = adcr_pkg::ST_RESP;
            end
            default: begin
                next_state = adcr_pkg::ST_IDLE;
            end
        endcase
        next_hreadyout = (next_state != adcr_pkg::ST_WAIT);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= adcr_pkg::ST_IDLE;
            tgt <= adcr_pkg::TGT_NONE;
            idx <= '0;
            wr <= 1'b0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            state <= next_state;
            tgt <= next_tgt;
            idx <= next_idx;
            wr <= next_wr;
            o_hreadyout <= next_hreadyout;
            o_hresp <= 1'b0;
        end
    end

    // ============================================================
    // read data
    // results are read-only; writes to them and to unmapped words are dropped
    always_comb begin
        next_hrdata = o_hrdata;
        if (state == adcr_pkg::ST_WAIT && !wr) begin
            case (tgt)
                adcr_pkg::TGT_RESULT: next_hrdata = {16'h0000, mem_rd_data};
                adcr_pkg::TGT_CTRL: next_hrdata = {25'h0000000, ctrl[idx]};
                adcr_pkg::TGT_STATUS: next_hrdata = {24'h000000, o_new_result};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_hrdata <= 32'h00000000;
        end else begin
            o_hrdata <= next_hrdata;
        end
    end

    // ============================================================
    // conversion control registers
    for (genvar g = 0; g < CH_N; g++) begin : g_ctrl
        always_comb begin
            next_ctrl[g] = ctrl[g];
            if (state == adcr_pkg::ST_WAIT && wr && tgt == adcr_pkg::TGT_CTRL
                    && idx == CH_W'(g)) begin
                next_ctrl[g] = i_hwdata[`ADCR_CTRL_W-1:0];
            end
        end

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                ctrl[g] <= `ADCR_CTRL_RESET;
            end else begin
                ctrl[g] <= next_ctrl[g];
            end
        end
    end

    // ============================================================
    // result path
    // resolution is taken from the channel's control word when the conversion ends
    adcr_justify #(
        .MAG_W(MAG_W),
        .RES_W(RES_W),
        .CH_W(CH_W)
    ) u_justify (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(i_conv_done),
        .i_channel(i_conv_channel),
        .i_sign(i_conv_sign),
        .i_magnitude(i_conv_magnitude),
        .i_resolution(ctrl[i_conv_channel][`ADCR_RES_MSB:`ADCR_RES_LSB]),
        .o_valid(fmt_valid),
        .o_channel(fmt_channel),
        .o_word(fmt_word)
    );

    adcr_result_mem #(
        .DEPTH(CH_N),
        .WIDTH(MAG_W + 1),
        .AW(CH_W)
    ) u_mem (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_wr_en(fmt_valid),
        .i_wr_addr(fmt_channel),
        .i_wr_data(fmt_word),
        .i_rd_en(accept && dec_target == adcr_pkg::TGT_RESULT),
        .i_rd_addr(dec_index),
        .o_rd_data(mem_rd_data)
    );

    // ============================================================
    // new-result flags: set on store, cleared by reading that result
    assign status_clear = state == adcr_pkg::ST_WAIT && !wr && tgt == adcr_pkg::TGT_RESULT;

    for (genvar g = 0; g < CH_N; g++) begin : g_flag
        always_comb begin
            next_new_result[g] = o_new_result[g];
            if (status_clear && idx == CH_W'(g)) begin
                next_new_result[g] = 1'b0;
            end
            // a store in the clearing cycle wins
            if (fmt_valid && fmt_channel == CH_W'(g)) begin
                next_new_result[g] = 1'b1;
            end
        end
    end

    always_comb begin
        next_active_resolution = o_active_resolution;
        if (i_conv_done) begin
            next_active_resolution = ctrl[i_conv_channel][`ADCR_RES_MSB:`ADCR_RES_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_new_result <= 8'h00;
            o_active_resolution <= 3'h7;
        end else begin
            o_new_result <= next_new_result;
            o_active_resolution <= next_active_resolution;
        end
    end

endmodule // adcr_result_bank

// ===== adcr_result_bank_checker.sv
/*
 * Assertions on the ports of the conversion result bank.
 * Assumes one clock, a synchronous active-high reset and hready looped back.
 */
`timescale 1ns/1ps

module adcr_result_bank_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [31:0] o_hrdata,
    // converter side
    input wire logic i_conv_done,
    input wire logic [2:0] i_conv_channel,
    input wire logic [7:0] o_new_result,
    input wire logic [2:0] o_active_resolution
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // ============================================================
    // bus transfer steps
    sequence s_taken;
        i_hsel && i_hready && i_htrans[1];
    endsequence
    sequence s_one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    // ============================================================
    // assertions
    a_one_wait: assert property (s_taken |=> s_one_wait)
        else $error("transfer did not take exactly one wait state");
    a_no_stray_wait: assert property (!(i_hsel && i_hready && i_htrans[1]) |=> o_hreadyout)
        else $error("wait state without a transfer");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("response not okay");
    a_upper_zero: assert property (o_hreadyout |-> o_hrdata[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");
    a_flag_set: assert property (i_conv_done |-> ##2 o_new_result[$past(i_conv_channel, 2)])
        else $error("new result flag not set two cycles after conversion");
    a_flag_rise: assert property ((o_new_result & ~$past(o_new_result)) != 8'h00
        |-> $past(i_conv_done, 2))
        else $error("new result flag set without conversion");
    a_flag_fall: assert property ((~o_new_result & $past(o_new_result)) != 8'h00
        |-> !$past(o_hreadyout))
        else $error("new result flag cleared outside a read");
    a_res_hold: assert property (!i_conv_done |=> $stable(o_active_resolution))
        else $error("active resolution changed without conversion");
    // read data may only move when a data phase ends, so a word is never seen half built
    a_rdata_hold: assert property ($changed(o_hrdata) |-> $rose(o_hreadyout))
        else $error("read data changed outside a data phase end");
endmodule // adcr_result_bank_checker

bind adcr_result_bank adcr_result_bank_checker adcr_result_bank_checker_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_hsel(i_hsel),
    .i_htrans(i_htrans),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .i_conv_done(i_conv_done),
    .i_conv_channel(i_conv_channel),
    .o_new_result(o_new_result),
    .o_active_resolution(o_active_resolution)
);

// ===== adcr_result_bank_tb.sv
/*
 * Self-checking bench for the conversion result bank: reset values,
 * every resolution code, flags, back-to-back and random conversions.
 * Assumes one slave on the bus, so hready is the slave's hreadyout.
 */
`timescale 1ns/1ps

module adcr_result_bank_tb;
    logic i_clk, i_reset, i_hsel, i_hwrite, i_conv_done, i_conv_sign;
    logic [31:0] i_haddr;
    logic [31:0] i_hwdata;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [2:0] i_conv_channel;
    logic [14:0] i_conv_magnitude;
    logic o_hreadyout, o_hresp;
    logic [31:0] o_hrdata;
    logic [7:0] o_new_result;
    logic [2:0] o_active_resolution;
    logic [2:0] ctrl_res [8];
    logic [31:0] rd;
    int bad_count, total_checks, seed;

    adcr_result_bank adcr_result_bank_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_hrdata(o_hrdata), .i_conv_done(i_conv_done), .i_conv_channel(i_conv_channel),
        .i_conv_sign(i_conv_sign), .i_conv_magnitude(i_conv_magnitude),
        .o_new_result(o_new_result), .o_active_resolution(o_active_resolution)
    );

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ============================================================
    // report
    task automatic wrap_up();
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ============================================================
    // bus master: ready is sampled just after the edge, before updates land
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 20);
        if (o_hreadyout !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        i_htrans <= 2'h2;
        i_haddr <= {24'h000000, a};
        i_hwrite <= wr;
        wait_ready();
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_ready();
        rdat = o_hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] v;
        bus(1'b0, a, 32'h00000000, v);
        chk(name, exp, v);
    endtask

    // ============================================================
    // expectations: low bits past the resolution read as zero
    function automatic logic [31:0] exp_word(input logic [2:0] r, input logic s,
                                             input logic [14:0] m);
        logic [15:0] mk;
        logic [14:0] v;
        mk = (16'h0001 << (r + 4'h8)) - 16'h0001;
        v = (m & mk[14:0]) << (3'h7 - r);
        return {16'h0000, s, v};
    endfunction

    task automatic conv(input logic [2:0] ch, input logic s, input logic [14:0] m);
        i_conv_done <= 1'b1;
        i_conv_channel <= ch;
        i_conv_sign <= s;
        i_conv_magnitude <= m;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
        @(posedge i_clk);
        chk("active_resolution", {29'h0, ctrl_res[ch]}, {29'h0, o_active_resolution});
        @(posedge i_clk);
    endtask

    task automatic one_conv(input logic [2:0] ch, input logic [2:0] r, input logic s,
                            input logic [14:0] m);
        logic [7:0] ra;
        ra = 8'h40 + {3'h0, ch, 2'h0};
        bus(1'b1, 8'h20 + {3'h0, ch, 2'h0}, {25'h0, r, 4'h0}, rd);
        ctrl_res[ch] = r;
        conv(ch, s, m);
        chk("new_result", 32'h1 << ch, {24'h000000, o_new_result});
        rd_chk(8'h60, 32'h1 << ch, "status_set");
        bus(1'b1, ra, 32'hFFFFFFFF, rd);
        rd_chk(ra, exp_word(r, s, m), "result");
        rd_chk(8'h60, 32'h0, "status_clear");
    endtask

    // ============================================================
    // main sequence
    initial begin
        seed = 32'h7371;
        bad_count = 0;
        total_checks = 0;
        i_reset = 1'b1;
        i_hsel = 1'b1;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = 32'h0;
        i_conv_done = 1'b0;
        i_conv_channel = 3'h0;
        i_conv_sign = 1'b0;
        i_conv_magnitude = 15'h0;
        for (int i = 0; i < 8; i++) begin
            ctrl_res[i] = 3'h7;
        end
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        // reset state, writes to results and unmapped places are dropped
        bus(1'b1, 8'h00, 32'hFFFFFFFF, rd);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h40 + 8'(i * 4), 32'hFFFF, rd);
            rd_chk(8'h40 + 8'(i * 4), 32'h0, "result_reset");
            rd_chk(8'h20 + 8'(i * 4), 32'h70, "ctrl_reset");
        end
        rd_chk(8'h00, 32'h0, "unmapped");
        rd_chk(8'h60, 32'h0, "status_reset");
        // every resolution code, one per channel
        for (int i = 0; i < 8; i++) begin
            one_conv(3'(i), 3'(i), i[0], 15'($random(seed)));
        end
        // corners: full scale, zero, full scale cut to eight bits
        one_conv(3'h7, 3'h7, 1'b1, 15'h7FFF);
        one_conv(3'h0, 3'h0, 1'b0, 15'h0000);
        one_conv(3'h2, 3'h0, 1'b1, 15'h7FFF);
        // back-to-back conversions: the later word replaces the earlier whole
        i_conv_done <= 1'b1;
        i_conv_channel <= 3'h5;
        i_conv_sign <= 1'b0;
        i_conv_magnitude <= 15'h1234;
        @(posedge i_clk);
        i_conv_sign <= 1'b1;
        i_conv_magnitude <= 15'h0555;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd_chk(8'h54, exp_word(ctrl_res[5], 1'b1, 15'h0555), "back_to_back");
        // random traffic
        for (int i = 0; i < 40; i++) begin
            one_conv(3'($random(seed)), 3'($random(seed)), 1'($random(seed)),
                     15'($random(seed)));
        end
        // mid-run reset with a store in flight: the store must not survive
        i_conv_done <= 1'b1;
        i_conv_channel <= 3'h1;
        i_conv_magnitude <= 15'h7FFF;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        chk("reset_resolution", 32'h7, {29'h0, o_active_resolution});
        chk("reset_flags", 32'h0, {24'h000000, o_new_result});
        rd_chk(8'h24, 32'h70, "ctrl_after_reset");
        rd_chk(8'h44, 32'h0, "result_after_reset");
        rd_chk(8'h60, 32'h0, "status_after_reset");
        wrap_up();
    end
endmodule // adcr_result_bank_tb
